// file: common/adc_port_pkg.sv
// shared constants of the parallel adc port and its host controller
package adc_port_pkg;
	localparam int CLK_MHZ       = 100;
	localparam int CH_COUNT      = 8;
	localparam int BUS_W         = 16;
	localparam int CFG_W         = 4;
	localparam int RES_WIDE      = 16;
	localparam int RES_NARROW    = 14;
	localparam int MODE_BIT      = 0;
	localparam logic [3:0] CFG_RESET = 4'h0;
	// device timing; longest times round down
	localparam int CONV_NS       = 3000;
	localparam int CONV_CYC      = CONV_NS * CLK_MHZ / 1000;
	localparam int EOC_RISE_NS   = 140;
	localparam int EOC_RISE_CYC  = EOC_RISE_NS * CLK_MHZ / 1000;
	localparam int SYNC_LAT      = 4;
	localparam int CONV_LOAD     = CONV_CYC - SYNC_LAT;
	// host timing; least times round up
	localparam int QUIET_NS      = 500;
	localparam int QUIET_CYC     = (QUIET_NS * CLK_MHZ + 999) / 1000;
	localparam int CONV_LOW_NS   = 20;
	localparam int CONV_LOW_CYC  = (CONV_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int WR_LOW_NS     = 20;
	localparam int WR_LOW_CYC    = (WR_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int RD_HIGH_NS    = 10;
	localparam int RD_HIGH_CYC   = (RD_HIGH_NS * CLK_MHZ + 999) / 1000;
	localparam int RD_VALID_NS   = 35;
	localparam int RD_VALID_CYC  = (RD_VALID_NS * CLK_MHZ + 999) / 1000;
	localparam int HOST_SYNC     = 2;
	localparam int RD_HOLD_CYC   = RD_VALID_CYC + SYNC_LAT + HOST_SYNC;
	// host register map
	localparam logic [11:0] CTRL_OFS     = 12'h000;
	localparam logic [11:0] STAT_OFS     = 12'h004;
	localparam logic [11:0] IRQ_STAT_OFS = 12'h008;
	localparam logic [11:0] IRQ_MASK_OFS = 12'h00c;
	localparam logic [11:0] DATA_OFS     = 12'h010;
	localparam int CTRL_START    = 0;
	localparam int CTRL_CFG_WR   = 1;
	localparam int CTRL_PD       = 2;
	localparam int CTRL_CFG_LSB  = 4;
	localparam int STAT_BUSY     = 0;
	localparam int STAT_EOC      = 1;
	localparam int IRQ_EOC       = 0;
	localparam int IRQ_DONE      = 1;
	localparam int IRQ_W         = 2;
endpackage

// file: common/adc_port_if.sv
// pin bundle between the converter port and its host
`timescale 1ns/1ps
interface adc_port_if;
	logic        conv_start;
	logic        cs_n;
	logic        rd_n;
	logic        wr_n;
	logic        power_down_in;
	logic [1:0]  cfg_dedicated;
	logic        eoc_n;
	logic [15:0] dev_db_out;
	logic        dev_db_oe;
	logic [15:0] host_db_out;
	logic        host_db_oe;
	logic [15:0] data_bus_lines;

	// resolved bus level; undriven lines read as zero
	assign data_bus_lines = dev_db_oe ? dev_db_out :
		(host_db_oe ? host_db_out : 16'h0000);

	modport dev (input conv_start, cs_n, rd_n, wr_n, power_down_in,
		cfg_dedicated, data_bus_lines,
		output eoc_n, dev_db_out, dev_db_oe);
	modport host (output conv_start, cs_n, rd_n, wr_n, power_down_in,
		cfg_dedicated, host_db_out, host_db_oe,
		input eoc_n, data_bus_lines);
endinterface

// file: design/adc_port_device.sv
// converter side: track/hold, conversion timing, readout and config port
`timescale 1ns/1ps
// Contract
// [RULE1] done line low at finish, high on start
// [RULE2] done falls within 3 us of start
// [RULE3] done rises within 140 ns of start
// [RULE4] start edge holds all channels together
// [RULE5] mode 0 tracks while start held low
// [RULE6] host keeps start high until done falls
// [RULE7] mode 1 start low pulse at least 20 ns
// [RULE8] select high 500 ns before start edge
// [RULE9] strobes stay high through quiet and conversion
// [RULE10] select held low for every access
// [RULE11] each read rise moves to next channel
// [RULE12] bus released when read or select high
// [RULE13] config latched on write rise with select
// [RULE14] wide variant config on lines 0 to 3
// [RULE15] wide variant result on lines 0 to 15
// [RULE16] power-down high keeps device asleep
// [RULE17] config survives power-down
// [RULE18] narrow variant: lines 0-13, split config
// [RULE19] readout restarts at channel 0 each conversion
module adc_port_device #(
	parameter int RES_BITS = adc_port_pkg::RES_WIDE,
	parameter int CH_USED  = adc_port_pkg::CH_COUNT
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic [8*16-1:0]      analog_code,
	output logic [3:0]                config_input_bits_reg,
	output logic                      busy_reg,
	output logic                      asleep_reg,
	adc_port_if.dev                   port
);
	typedef enum {CV_TRACK, CV_CONVERT, CV_SLEEP} conv_state_t;

	localparam bit NARROW = (RES_BITS == adc_port_pkg::RES_NARROW);

	conv_state_t  state_reg;
	logic [8:0]   cnt_reg;
	logic [2:0]   ptr_reg;
	logic [15:0]  held_reg [8];
	logic [15:0]  result_reg [8];
	logic [15:0]  db_out_reg;
	logic         db_oe_reg;
	logic         eoc_n_reg;
	logic [4:0]   pin_s1;
	logic [4:0]   pin_s2;
	logic [4:0]   pin_prev;
	logic [15:0]  db_s1;
	logic [15:0]  db_s2;
	logic [1:0]   ded_s1;
	logic [1:0]   ded_s2;
	logic         conv_rise;
	logic         rd_rise;
	logic         wr_rise;
	logic         sleep;
	logic         tracking;
	logic         conv_end;

	// present a code at the variant's resolution, low lines first
	function automatic logic [15:0] fmt_word(input logic [15:0] code);
		if (NARROW) begin
			return {2'b00, code[15:2]};
		end
		return code;
	endfunction

	// two-stage synchronisers on every pin from the host
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1 <= 5'h1e;
			pin_s2 <= 5'h1e;
			pin_prev <= 5'h1e;
			db_s1 <= 16'h0000;
			db_s2 <= 16'h0000;
			ded_s1 <= 2'h0;
			ded_s2 <= 2'h0;
		end else begin
			pin_s1 <= {port.power_down_in, port.wr_n, port.rd_n,
				port.cs_n, port.conv_start};
			pin_s2 <= pin_s1;
			pin_prev <= pin_s2;
			db_s1 <= port.data_bus_lines;
			db_s2 <= db_s1;
			ded_s1 <= port.cfg_dedicated;
			ded_s2 <= ded_s1;
		end
	end

	// edge detection works on the second stage only
	assign conv_rise = pin_s2[0] & ~pin_prev[0];
	assign rd_rise = pin_s2[2] & ~pin_prev[2] & ~pin_s2[1];
	assign wr_rise = pin_s2[3] & ~pin_prev[3] & ~pin_s2[1]; // [RULE13]
	assign sleep = pin_s2[4];
	assign conv_end = (state_reg == CV_CONVERT) && (cnt_reg == 9'd1);
	// mode 0 tracks only while start is low; mode 1 whenever idle
	assign tracking = (state_reg == CV_TRACK) &&
		(config_input_bits_reg[adc_port_pkg::MODE_BIT] ||
		!pin_s2[0]); // [RULE5]

	// conversion sequencing; power-down takes priority over all
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= CV_TRACK;
			cnt_reg <= 9'd0;
		end else begin
			case (state_reg)
				CV_TRACK: begin
					if (sleep) begin
						state_reg <= CV_SLEEP; // [RULE16]
					end else if (conv_rise) begin
						state_reg <= CV_CONVERT; // [RULE4]
						cnt_reg <= 9'(adc_port_pkg::CONV_LOAD); // [RULE2]
					end
				end
				CV_CONVERT: begin
					if (sleep) begin
						state_reg <= CV_SLEEP; // [RULE16]
					end else if (conv_rise) begin
						cnt_reg <= 9'(adc_port_pkg::CONV_LOAD);
					end else if (conv_end) begin
						state_reg <= CV_TRACK;
						cnt_reg <= 9'd0;
					end else begin
						cnt_reg <= cnt_reg - 9'd1;
					end
				end
				CV_SLEEP: begin
					if (!sleep) begin
						state_reg <= CV_TRACK;
					end
				end
				default: begin
					state_reg <= CV_TRACK;
				end
			endcase
		end
	end

	// done line: high on a new start, low when the count runs out
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eoc_n_reg <= 1'b1;
		end else if (conv_rise && !sleep) begin
			eoc_n_reg <= 1'b1; // [RULE1] [RULE3]
		end else if (conv_end && !sleep) begin
			eoc_n_reg <= 1'b0; // [RULE1] [RULE2]
		end
	end

	// one track/hold per channel, all frozen by the same start edge
	genvar ch;
	generate
		for (ch = 0; ch < 8; ch++) begin : g_th
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					held_reg[ch] <= 16'h0000;
					result_reg[ch] <= 16'h0000;
				end else begin
					if (tracking && !conv_rise) begin
						held_reg[ch] <= analog_code[ch*16 +: 16]; // [RULE4]
					end
					if (conv_end && !sleep && !conv_rise) begin
						result_reg[ch] <= held_reg[ch];
					end
				end
			end
		end
	endgenerate

	// readout pointer: back to channel 0 after each conversion
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr_reg <= 3'd0;
		end else if (conv_end && !sleep && !conv_rise) begin
			ptr_reg <= 3'd0; // [RULE19]
		end else if (rd_rise && state_reg != CV_SLEEP) begin
			if (ptr_reg == 3'(CH_USED - 1)) begin
				ptr_reg <= 3'd0; // [RULE19]
			end else begin
				ptr_reg <= ptr_reg + 3'd1; // [RULE11]
			end
		end
	end

	// data lines: driven only while read and select are both low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			db_out_reg <= 16'h0000;
			db_oe_reg <= 1'b0;
		end else begin
			db_out_reg <= fmt_word(result_reg[ptr_reg]); // [RULE15] [RULE18]
			db_oe_reg <= ~pin_s2[2] & ~pin_s2[1] &
				(state_reg != CV_SLEEP); // [RULE12]
		end
	end

	// config word; untouched by power-down
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			config_input_bits_reg <= adc_port_pkg::CFG_RESET;
		end else if (wr_rise && state_reg != CV_SLEEP) begin
			if (NARROW) begin
				config_input_bits_reg <= {db_s2[1:0], ded_s2}; // [RULE18]
			end else begin
				config_input_bits_reg <= db_s2[3:0]; // [RULE14]
			end
		end
	end

	// status seen by the user side
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_reg <= 1'b0;
			asleep_reg <= 1'b0;
		end else begin
			busy_reg <= (state_reg == CV_CONVERT);
			asleep_reg <= (state_reg == CV_SLEEP); // [RULE17]
		end
	end

	assign port.eoc_n = eoc_n_reg;
	assign port.dev_db_out = db_out_reg;
	assign port.dev_db_oe = db_oe_reg;
endmodule // adc_port_device

// file: design/adc_port_host.sv
// host side: apb registers driving the converter strobes
`timescale 1ns/1ps
module adc_port_host #(
	parameter int RES_BITS = adc_port_pkg::RES_WIDE,
	parameter int CH_USED  = adc_port_pkg::CH_COUNT
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [11:0]  paddr,
	input  wire logic [31:0]  pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	output logic              irq,
	adc_port_if.host          port
);
	typedef enum {H_IDLE, H_CFG_CS, H_CFG_WR, H_CFG_END, H_QUIET,
		H_EOC_HI, H_EOC_LO, H_RD_LO, H_RD_HI} host_state_t;

	localparam bit NARROW = (RES_BITS == adc_port_pkg::RES_NARROW);

	host_state_t  st_reg;
	logic [7:0]   cnt_reg;
	logic [2:0]   ch_reg;
	logic [15:0]  data_reg [8];
	logic [3:0]   cfg_val_reg;
	logic         pd_reg;
	logic         start_pend_reg;
	logic         cfg_pend_reg;
	logic [1:0]   irq_stat_reg;
	logic [1:0]   irq_mask_reg;
	logic [1:0]   irq_set;
	logic         conv_reg;
	logic         cs_n_reg;
	logic         rd_n_reg;
	logic         wr_n_reg;
	logic [15:0]  db_out_reg;
	logic         db_oe_reg;
	logic [1:0]   ded_reg;
	logic         eoc_s1;
	logic         eoc_s2;
	logic [15:0]  db_s1;
	logic [15:0]  db_s2;
	logic         wr_en;
	logic         take_cfg;
	logic         take_start;

	// word decode: valid offsets of the map
	function automatic logic addr_ok(input logic [11:0] a);
		return (a <= adc_port_pkg::IRQ_MASK_OFS && a[1:0] == 2'b00) ||
			(a >= adc_port_pkg::DATA_OFS && a[1:0] == 2'b00 &&
			a < adc_port_pkg::DATA_OFS + 12'(4 * CH_USED));
	endfunction

	function automatic logic [31:0] rd_mux(input logic [11:0] a);
		logic [11:0] di;
		di = a - adc_port_pkg::DATA_OFS;
		case (a)
			adc_port_pkg::CTRL_OFS:
				return {24'h0, cfg_val_reg, 1'b0, pd_reg, 2'b00};
			adc_port_pkg::STAT_OFS:
				return {30'h0, eoc_s2, st_reg != H_IDLE};
			adc_port_pkg::IRQ_STAT_OFS: return {30'h0, irq_stat_reg};
			adc_port_pkg::IRQ_MASK_OFS: return {30'h0, irq_mask_reg};
			default: begin
				if (addr_ok(a) && a >= adc_port_pkg::DATA_OFS) begin
					return {16'h0, data_reg[di[4:2]]};
				end
				return 32'h0;
			end
		endcase
	endfunction

	assign wr_en = psel & penable & pready & pwrite & addr_ok(paddr);
	assign take_cfg = (st_reg == H_IDLE) && cfg_pend_reg;
	assign take_start = (st_reg == H_IDLE) && !cfg_pend_reg &&
		start_pend_reg;

	// apb answer: one wait-free access phase after each setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			prdata <= (psel & ~penable & ~pwrite) ? rd_mux(paddr) : 32'h0;
			pslverr <= psel & ~penable & ~addr_ok(paddr);
		end
	end

	// control registers; a pending order is held until the sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_val_reg <= adc_port_pkg::CFG_RESET;
			pd_reg <= 1'b0;
			start_pend_reg <= 1'b0;
			cfg_pend_reg <= 1'b0;
			irq_mask_reg <= 2'b00;
		end else begin
			start_pend_reg <= (start_pend_reg & ~take_start) | (wr_en &&
				paddr == adc_port_pkg::CTRL_OFS &&
				pwdata[adc_port_pkg::CTRL_START]);
			cfg_pend_reg <= (cfg_pend_reg & ~take_cfg) | (wr_en &&
				paddr == adc_port_pkg::CTRL_OFS &&
				pwdata[adc_port_pkg::CTRL_CFG_WR]);
			if (wr_en && paddr == adc_port_pkg::CTRL_OFS) begin
				pd_reg <= pwdata[adc_port_pkg::CTRL_PD];
				cfg_val_reg <= pwdata[adc_port_pkg::CTRL_CFG_LSB +: 4];
			end
			if (wr_en && paddr == adc_port_pkg::IRQ_MASK_OFS) begin
				irq_mask_reg <= pwdata[1:0];
			end
		end
	end

	// sticky events, write one to clear; a new event wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_reg <= 2'b00;
			irq <= 1'b0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~((wr_en && paddr ==
				adc_port_pkg::IRQ_STAT_OFS) ? pwdata[1:0] : 2'b00)) |
				irq_set;
			irq <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	// pins from the converter pass two flip-flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eoc_s1 <= 1'b1;
			eoc_s2 <= 1'b1;
			db_s1 <= 16'h0000;
			db_s2 <= 16'h0000;
		end else begin
			eoc_s1 <= port.eoc_n;
			eoc_s2 <= eoc_s1;
			db_s1 <= port.data_bus_lines;
			db_s2 <= db_s1;
		end
	end

	assign irq_set[adc_port_pkg::IRQ_EOC] = (st_reg == H_EOC_LO) && !eoc_s2;
	assign irq_set[adc_port_pkg::IRQ_DONE] = (st_reg == H_RD_HI) &&
		(cnt_reg == 8'd0) && (ch_reg == 3'(CH_USED - 1));

	// strobe sequencer: config write, quiet, convert, read all channels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= H_IDLE;
			cnt_reg <= 8'd0;
			ch_reg <= 3'd0;
			conv_reg <= 1'b0;
			cs_n_reg <= 1'b1;
			rd_n_reg <= 1'b1;
			wr_n_reg <= 1'b1;
			db_out_reg <= 16'h0000;
			db_oe_reg <= 1'b0;
			ded_reg <= 2'b00;
		end else begin
			case (st_reg)
				H_IDLE: begin
					if (take_cfg) begin
						cs_n_reg <= 1'b0; // [RULE10]
						db_oe_reg <= 1'b1;
						if (NARROW) begin
							db_out_reg <= {14'h0, cfg_val_reg[3:2]}; // [RULE18]
							ded_reg <= cfg_val_reg[1:0]; // [RULE18]
						end else begin
							db_out_reg <= {12'h0, cfg_val_reg}; // [RULE14]
						end
						st_reg <= H_CFG_CS;
					end else if (take_start) begin
						cnt_reg <= 8'(adc_port_pkg::QUIET_CYC - 1);
						st_reg <= H_QUIET;
					end
				end
				H_CFG_CS: begin
					wr_n_reg <= 1'b0;
					cnt_reg <= 8'(adc_port_pkg::WR_LOW_CYC - 1);
					st_reg <= H_CFG_WR;
				end
				H_CFG_WR: begin
					if (cnt_reg == 8'd0) begin
						wr_n_reg <= 1'b1;
						st_reg <= H_CFG_END;
					end else begin
						cnt_reg <= cnt_reg - 8'd1;
					end
				end
				H_CFG_END: begin
					cs_n_reg <= 1'b1;
					db_oe_reg <= 1'b0;
					st_reg <= H_IDLE;
				end
				H_QUIET: begin
					if (cnt_reg == 8'd0) begin
						conv_reg <= 1'b1; // [RULE7] [RULE8] [RULE9]
						st_reg <= H_EOC_HI;
					end else begin
						cnt_reg <= cnt_reg - 8'd1;
					end
				end
				H_EOC_HI: begin
					if (eoc_s2) begin
						st_reg <= H_EOC_LO;
					end
				end
				H_EOC_LO: begin
					if (!eoc_s2) begin
						conv_reg <= 1'b0; // [RULE6]
						cs_n_reg <= 1'b0; // [RULE10]
						rd_n_reg <= 1'b0;
						ch_reg <= 3'd0;
						cnt_reg <= 8'(adc_port_pkg::RD_HOLD_CYC - 1);
						st_reg <= H_RD_LO;
					end
				end
				H_RD_LO: begin
					if (cnt_reg == 8'd0) begin
						data_reg[ch_reg] <= db_s2;
						rd_n_reg <= 1'b1;
						cnt_reg <= 8'(adc_port_pkg::RD_HIGH_CYC - 1);
						st_reg <= H_RD_HI;
					end else begin
						cnt_reg <= cnt_reg - 8'd1;
					end
				end
				H_RD_HI: begin
					if (cnt_reg != 8'd0) begin
						cnt_reg <= cnt_reg - 8'd1;
					end else if (ch_reg == 3'(CH_USED - 1)) begin
						cs_n_reg <= 1'b1;
						st_reg <= H_IDLE;
					end else begin
						ch_reg <= ch_reg + 3'd1;
						rd_n_reg <= 1'b0;
						cnt_reg <= 8'(adc_port_pkg::RD_HOLD_CYC - 1);
						st_reg <= H_RD_LO;
					end
				end
				default: begin
					st_reg <= H_IDLE;
				end
			endcase
		end
	end

	assign port.conv_start = conv_reg;
	assign port.cs_n = cs_n_reg;
	assign port.rd_n = rd_n_reg;
	assign port.wr_n = wr_n_reg;
	assign port.power_down_in = pd_reg;
	assign port.cfg_dedicated = ded_reg;
	assign port.host_db_out = db_out_reg;
	assign port.host_db_oe = db_oe_reg;
endmodule // adc_port_host

// file: dv/adc_port_monitor.sv
// concurrent checks on the pins between converter port and host
`timescale 1ns/1ps
module adc_port_monitor (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        conv_start,
	input wire logic        cs_n,
	input wire logic        rd_n,
	input wire logic        wr_n,
	input wire logic        power_down_in,
	input wire logic        eoc_n,
	input wire logic        dev_db_oe,
	input wire logic        host_db_oe
);
	int quiet_cnt_reg;

	// counts cycles with every strobe idle, saturating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			quiet_cnt_reg <= 0;
		end else if (!(cs_n && rd_n && wr_n)) begin
			quiet_cnt_reg <= 0;
		end else if (quiet_cnt_reg < 63) begin
			quiet_cnt_reg <= quiet_cnt_reg + 1;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// done line reacts to start edges within the bounds
	chk_eoc_rise_fast: assert property ($rose(conv_start) && !power_down_in
		|-> ##[1:14] eoc_n) else $error("done line late to rise");
	chk_eoc_fall_bound: assert property ($rose(conv_start) |->
		##[1:300] (!eoc_n || power_down_in))
		else $error("conversion longer than allowed");
	chk_eoc_held_low: assert property (!eoc_n && !conv_start |=> !eoc_n)
		else $error("done line rose without a start");
	// data bus ownership
	chk_bus_release: assert property ((rd_n || cs_n) [*4] |-> !dev_db_oe)
		else $error("device drives bus while deselected");
	chk_bus_single: assert property (!(dev_db_oe && host_db_oe))
		else $error("both ends drive the bus");
	chk_read_drive: assert property ((!rd_n && !cs_n && !power_down_in) [*4]
		|-> dev_db_oe) else $error("device silent during read");
	// host obligations on the strobes
	chk_quiet_time: assert property ($rose(conv_start)
		|-> $past(quiet_cnt_reg) >= adc_port_pkg::QUIET_CYC)
		else $error("quiet time too short");
	chk_access_select: assert property ((!rd_n || !wr_n) |-> !cs_n)
		else $error("strobe without chip select");
	chk_start_release: assert property ($fell(conv_start) && !power_down_in
		|-> !eoc_n) else $error("start lowered before done");
	chk_start_low_time: assert property ($fell(conv_start)
		|-> !conv_start [*2]) else $error("start low pulse too short");
endmodule // adc_port_monitor

// file: dv/sim_sampling_adc_host_port_test.sv
// self-checking bench: host and converter joined over the pin bundle
`timescale 1ns/1ps
`define CHECK(got, exp) begin checks++; if ((got) !== (exp)) begin \
	num_errors++; $display("Error at %0t: got %h expected %h", $time, \
	got, exp); end end
module sim_sampling_adc_host_port_test;
	logic         pclk;
	logic         presetn;
	logic         psel;
	logic         penable;
	logic         pwrite;
	logic [11:0]  paddr;
	logic [31:0]  pwdata;
	logic [31:0]  prdata;
	logic         pready;
	logic         pslverr;
	logic         irq;
	logic [127:0] analog_code;
	logic [3:0]   config_input_bits_reg;
	logic         busy_reg;
	logic         asleep_reg;
	logic [3:0]   cfg_now;
	int           num_errors;
	int           checks;
	logic [31:0]  prdata_n;
	logic [31:0]  last_n;
	logic [3:0]   cfg_n;
	logic         irq_n;

	localparam int NARROW_CH = 6;

	adc_port_if link();
	adc_port_if link_n();

	adc_port_device u_adc_port_device (.pclk(pclk), .presetn(presetn),
		.analog_code(analog_code),
		.config_input_bits_reg(config_input_bits_reg),
		.busy_reg(busy_reg), .asleep_reg(asleep_reg), .port(link));
	adc_port_host u_adc_port_host (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .port(link));
	adc_port_monitor u_adc_port_monitor (.pclk(pclk), .presetn(presetn),
		.conv_start(link.conv_start), .cs_n(link.cs_n), .rd_n(link.rd_n),
		.wr_n(link.wr_n), .power_down_in(link.power_down_in),
		.eoc_n(link.eoc_n), .dev_db_oe(link.dev_db_oe),
		.host_db_oe(link.host_db_oe));

	// narrow six-channel pair, given the same apb orders as the wide pair
	adc_port_device #(.RES_BITS(adc_port_pkg::RES_NARROW),
		.CH_USED(NARROW_CH)) u_adc_port_device_n (.pclk(pclk),
		.presetn(presetn), .analog_code(analog_code),
		.config_input_bits_reg(cfg_n), .busy_reg(), .asleep_reg(),
		.port(link_n));
	adc_port_host #(.RES_BITS(adc_port_pkg::RES_NARROW),
		.CH_USED(NARROW_CH)) u_adc_port_host_n (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata_n), .pready(), .pslverr(), .irq(irq_n),
		.port(link_n));

	// free-running 100 MHz clock
	always #5 pclk = ~pclk;

	// verdict and end of run
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic timed_out();
		num_errors++;
		summarize();
	endtask

	// one apb transfer, waiting for the slave's ready
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic err);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) timed_out();
		q = prdata;
		last_n = prdata_n;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
		`CHECK(e, 1'b0)
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		`CHECK(q, exp)
		`CHECK(e, 1'b0)
	endtask

	// register reset values and refused addresses
	task automatic t_reset_and_refuse();
		logic [31:0] q;
		logic e;
		rd_chk(adc_port_pkg::CTRL_OFS, 32'h0);
		rd_chk(adc_port_pkg::STAT_OFS, 32'h2);
		rd_chk(adc_port_pkg::IRQ_STAT_OFS, 32'h0);
		rd_chk(adc_port_pkg::IRQ_MASK_OFS, 32'h0);
		`CHECK(irq, 1'b0)
		`CHECK(config_input_bits_reg, adc_port_pkg::CFG_RESET)
		apb(1'b0, 12'h100, 32'h0, q, e);
		`CHECK(e, 1'b1)
		`CHECK(q, 32'h0)
		apb(1'b1, 12'h002, 32'hffff_ffff, q, e);
		`CHECK(e, 1'b1)
	endtask

	// config word carried on the low data lines, latched on write rise
	task automatic t_config(input logic [3:0] cfg);
		int n;
		cfg_now = cfg;
		wr(adc_port_pkg::CTRL_OFS, {24'h0, cfg, 4'h2});
		n = 0;
		while (config_input_bits_reg !== cfg && n < 40) begin
			@(posedge pclk);
			n++;
		end
		`CHECK(config_input_bits_reg, cfg)
		`CHECK(cfg_n, cfg)
		rd_chk(adc_port_pkg::CTRL_OFS, {24'h0, cfg, 4'h0});
	endtask

	// conversion, readout of every channel, interrupt with a given mask
	task automatic t_convert(input logic [3:0] seed, input logic [1:0] mask);
		logic [127:0] held;
		logic [31:0]  q;
		logic         e;
		int           n;
		logic [31:0]  exp_n;
		for (n = 0; n < 8; n++) begin
			held[n*16+:16] = {seed, n[3:0], ~seed, 4'h1 ^ n[3:0]};
		end
		analog_code <= held;
		wr(adc_port_pkg::IRQ_MASK_OFS, {30'h0, mask});
		wr(adc_port_pkg::CTRL_OFS, {24'h0, cfg_now, 4'h1});
		n = 0;
		while (busy_reg !== 1'b1 && n < 100) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 100) timed_out();
		repeat (5) @(posedge pclk);
		// inputs move after the start edge; results must not
		analog_code <= ~held;
		rd_chk(adc_port_pkg::STAT_OFS, 32'h3);
		n = 0;
		do begin
			apb(1'b0, adc_port_pkg::IRQ_STAT_OFS, 32'h0, q, e);
			n++;
		end while (q[adc_port_pkg::IRQ_DONE] !== 1'b1 && n < 400);
		if (n >= 400) timed_out();
		`CHECK(q[1:0], 2'b11)
		`CHECK(irq, |mask)
		`CHECK(irq_n, |mask)
		for (n = 0; n < 8; n++) begin
			rd_chk(adc_port_pkg::DATA_OFS + 12'(4 * n),
				{16'h0, held[n*16+:16]});
			// narrow words: top 14 bits on the low lines, none past the last
			exp_n = (n < NARROW_CH) ? {18'h0, held[n*16+2+:14]} : 32'h0;
			`CHECK(last_n, exp_n)
		end
		wr(adc_port_pkg::IRQ_STAT_OFS, 32'h3);
		rd_chk(adc_port_pkg::IRQ_STAT_OFS, 32'h0);
		`CHECK(irq, 1'b0)
		`CHECK(irq_n, 1'b0)
	endtask

	// power-down keeps the config and refuses writes
	task automatic t_sleep();
		wr(adc_port_pkg::CTRL_OFS, {24'h0, cfg_now, 4'h4});
		repeat (10) @(posedge pclk);
		`CHECK(asleep_reg, 1'b1)
		`CHECK(config_input_bits_reg, cfg_now)
		wr(adc_port_pkg::CTRL_OFS, {24'h0, ~cfg_now, 4'h6});
		repeat (20) @(posedge pclk);
		`CHECK(config_input_bits_reg, cfg_now)
		`CHECK(link.dev_db_oe, 1'b0)
		wr(adc_port_pkg::CTRL_OFS, {24'h0, cfg_now, 4'h0});
		repeat (10) @(posedge pclk);
		`CHECK(asleep_reg, 1'b0)
		`CHECK(config_input_bits_reg, cfg_now)
		`CHECK(cfg_n, cfg_now)
	endtask

	// main sequence
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		analog_code = '0;
		cfg_now = 4'h0;
		num_errors = 0;
		checks = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset_and_refuse();
		t_config(4'ha);
		t_convert(4'h3, 2'b11);
		t_convert(4'hc, 2'b00);
		t_config(4'h5);
		t_convert(4'h9, 2'b10);
		t_sleep();
		summarize();
	end
endmodule // sim_sampling_adc_host_port_test
